/* verilog/interrupt_priority_config.sv */
// APB priority registers, reset control register and interrupt steering.
//
// Overview of operation
// [R1] Three priority registers, one bit per source.
// [R2] Priority bits matter only while levels enabled.
// [R3] Priority bits read/write, 1 high, reset 1.
// [R4] Control bit 7 enables levels, resets 0.
// [R5] Bit 4 RW flag; bits 3,2 read-only; 6,5 zero.
// [R6] Bits 1,0 read/write status, reset 0.
// [R7] High requests served first and preempt low.
//
// Design decisions made here: the APB slave port and the register offsets.
`timescale 1ns/1ns
`default_nettype none
`include "prio_defs.svh"

module interrupt_priority_config
  import prio_pkg::*;
#(
  parameter int NSRC = 24
) (
  // Clock and asynchronous active-low reset.
  input  wire logic             clk,
  input  wire logic             rstn,
  // APB slave port.
  input  wire logic             psel,
  input  wire logic             penable,
  input  wire logic             pwrite,
  input  wire logic [11:0]      paddr,
  input  wire logic [31:0]      pwdata,
  output logic                  pready,
  output logic      [31:0]      prdata,
  output logic                  pslverr,
  // Hardware events that clear the read-only flags.
  input  wire logic             watchdog_timeout_event,
  input  wire logic             power_down_event,
  // Pending enabled requests from the peripherals.
  input  wire logic [NSRC-1:0]  irq_request,
  // Requests steered to the core.
  output logic                  irq_high,
  output logic                  irq_low,
  output logic      [4:0]       irq_index,
  output logic                  levels_enabled
);

  logic [7:0] prio_one;    // First priority register.
  logic [7:0] prio_two;    // Second priority register.
  logic [7:0] prio_three;  // Third priority register.
  ctrl_t      ctrl;        // Reset control and status register.
  resolve_t   res;         // Resolver output.
  logic [0:0] tie_unused;  // Resolver spare output, not used.

  // Bus phase decode.
  wire setup_phase = psel & ~penable;
  wire hit_one     = paddr == `PRIO_ONE_OFFSET;
  wire hit_two     = paddr == `PRIO_TWO_OFFSET;
  wire hit_three   = paddr == `PRIO_THREE_OFFSET;
  wire hit_ctrl    = paddr == `CTRL_OFFSET;
  wire mapped      = hit_one | hit_two | hit_three | hit_ctrl;
  // A write commits only at the completing access edge.
  wire wr_en       = psel & penable & pready & pwrite & mapped;

  // Read mux; the unused control bits always read zero, see [R5].
  ctrl_t ctrl_view;
  assign ctrl_view     = ctrl;
  wire [7:0] read_byte = hit_one   ? prio_one   :
                         hit_two   ? prio_two   :
                         hit_three ? prio_three :
                         hit_ctrl  ? {ctrl_view.priority_levels_enable,
                                      2'b00, ctrl_view[4:0]} : 8'h00;

  // Write data split into the control fields.
  wire [7:0] wbyte   = pwdata[7:0];
  wire       ctrl_wr = wr_en & hit_ctrl;
  ctrl_t next_ctrl;
  wire next_levels = ctrl_wr ? wbyte[`CTRL_LEVELS_BIT] :
                               ctrl.priority_levels_enable;  // see [R4]
  wire next_rst_instr = ctrl_wr ? wbyte[`CTRL_RST_INSTR_BIT] :
                                  ctrl.reset_instruction_flag;  // see [R5]
  // Read-only flags only ever fall by a hardware event, see [R5].
  wire next_wdog  = ctrl.watchdog_timeout_flag & ~watchdog_timeout_event;
  wire next_pwrdn = ctrl.power_down_flag & ~power_down_event;
  wire next_pwron = ctrl_wr ? wbyte[`CTRL_PWRON_BIT] :
                              ctrl.poweron_reset_status;  // see [R6]
  wire next_brownout = ctrl_wr ? wbyte[`CTRL_BROWNOUT_BIT] :
                                 ctrl.brownout_reset_status;  // see [R6]
  // One assignment keeps a single driver on the packed struct.
  assign next_ctrl = {next_levels, 2'b00, next_rst_instr, next_wdog,
                      next_pwrdn, next_pwron, next_brownout};

  // All three priority registers write the same way, see [R1] and [R3].
  wire [7:0] next_one   = (wr_en & hit_one)   ? wbyte : prio_one;
  wire [7:0] next_two   = (wr_en & hit_two)   ? wbyte : prio_two;
  wire [7:0] next_three = (wr_en & hit_three) ? wbyte : prio_three;

  // Priority registers; every source comes up high priority.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      prio_one   <= `PRIO_ONE_RESET;  // see [R3]
      prio_two   <= `PRIO_TWO_RESET;
      prio_three <= `PRIO_THREE_RESET;
    end else begin
      prio_one   <= next_one;
      prio_two   <= next_two;
      prio_three <= next_three;
    end
  end

  // Control register; the flags come up as the power-on pattern.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      ctrl <= `CTRL_RESET;  // see [R4] [R5] [R6]
    end else begin
      ctrl <= next_ctrl;
    end
  end

  // No wait states: data is prepared in setup so prdata is a flop.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      pready  <= 1'b0;
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else begin
      pready  <= setup_phase;
      prdata  <= setup_phase ? {24'h00_0000, read_byte} : prdata;
      pslverr <= setup_phase & ~mapped;
    end
  end

  // Priority bits of all sources, first register in the low bits.
  wire [23:0] all_prio = {prio_three, prio_two, prio_one};

  // Classify pending requests.
  priority_resolver #(
    .NSRC (NSRC)
  ) u_resolver (
    .req        (irq_request),
    .prio       (all_prio[NSRC-1:0]),
    .levels_on  (ctrl.priority_levels_enable),
    .unused_tie (tie_unused),
    .res        (res)
  );

  // High class wins; low is held off while any high request waits.
  // The core preempts a running low handler when irq_high rises.
  wire       next_high  = res.high_any;                      // see [R7]
  wire       next_low   = res.low_any & ~res.high_any;       // see [R7]
  wire [4:0] next_index = res.high_any ? res.high_index :
                          res.low_any  ? res.low_index : 5'h00;

  // Registered steering outputs.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      irq_high       <= 1'b0;
      irq_low        <= 1'b0;
      irq_index      <= 5'h00;
      levels_enabled <= 1'b0;
    end else begin
      irq_high       <= next_high;
      irq_low        <= next_low;
      irq_index      <= next_index;
      levels_enabled <= ctrl.priority_levels_enable;  // see [R2]
    end
  end

  // A lone low request under levels mode.
  sequence low_alone_s;
    res.low_any && !res.high_any && ctrl.priority_levels_enable;
  endsequence

  // Any high-class request.
  sequence high_pending_s;
    res.high_any;
  endsequence

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  prio_write_one_a: assert property ( // see [R3]
    wr_en && hit_one |=> prio_one == $past(pwdata[7:0]))
    else $error("first priority register missed a write");

  third_reg_read_a: assert property ( // see [R1]
    setup_phase && hit_three |=> prdata[7:0] == $past(prio_three))
    else $error("third priority register read wrong");

  legacy_no_low_a: assert property ( // see [R2]
    !ctrl.priority_levels_enable |=> !irq_low)
    else $error("low request signalled with levels off");

  levels_write_a: assert property ( // see [R4]
    wr_en && hit_ctrl |=>
      ctrl.priority_levels_enable == $past(pwdata[7]))
    else $error("levels enable missed a write");

  // The read data stands in the access cycle, when pready is high.
  gap_reads_zero_a: assert property ( // see [R5]
    setup_phase && hit_ctrl |=> prdata[6:5] == 2'b00 && pready)
    else $error("unused control bits read nonzero");

  flag_readonly_a: assert property ( // see [R5]
    wr_en && hit_ctrl && !watchdog_timeout_event |=>
      $stable(ctrl.watchdog_timeout_flag))
    else $error("watchdog flag changed by a write");

  status_write_a: assert property ( // see [R6]
    wr_en && hit_ctrl |=>
      {ctrl.poweron_reset_status, ctrl.brownout_reset_status}
        == $past(pwdata[1:0]))
    else $error("reset status bits missed a write");

  high_first_a: assert property ( // see [R7]
    high_pending_s |=> irq_high && !irq_low &&
      irq_index == $past(res.high_index))
    else $error("high request not served first");

  low_served_a: assert property ( // see [R7]
    low_alone_s |=> irq_low && !irq_high)
    else $error("lone low request not signalled");

endmodule

`default_nettype wire

/* shared/prio_defs.svh */
// Register offsets, field positions and reset values of the priority block.
`ifndef PRIO_DEFS_SVH
`define PRIO_DEFS_SVH

// Byte offsets of the registers on the APB port.
`define PRIO_ONE_OFFSET   12'h000
`define PRIO_TWO_OFFSET   12'h004
`define PRIO_THREE_OFFSET 12'h008
`define CTRL_OFFSET       12'h00C

// Reset values of the priority registers, all sources high priority.
`define PRIO_ONE_RESET    8'hFF
`define PRIO_TWO_RESET    8'hFF
`define PRIO_THREE_RESET  8'hFF

// Bit positions inside the reset control and status register.
`define CTRL_LEVELS_BIT     7
`define CTRL_RST_INSTR_BIT  4
`define CTRL_WDOG_BIT       3
`define CTRL_PWRDN_BIT      2
`define CTRL_PWRON_BIT      1
`define CTRL_BROWNOUT_BIT   0

// Reset value of the reset control and status register.
`define CTRL_RESET          8'h1C

`endif

/* shared/prio_pkg.sv */
// Types shared by the interrupt priority configuration block.
package prio_pkg;

  // Layout of the reset control and status register, bit 7 first.
  typedef struct packed {
    logic       priority_levels_enable;
    logic [1:0] gap;
    logic       reset_instruction_flag;
    logic       watchdog_timeout_flag;
    logic       power_down_flag;
    logic       poweron_reset_status;
    logic       brownout_reset_status;
  } ctrl_t;

  // What the resolver tells the top about the pending requests.
  typedef struct packed {
    logic       high_any;
    logic       low_any;
    logic [4:0] high_index;
    logic [4:0] low_index;
  } resolve_t;

endpackage

/* verilog/priority_resolver.sv */
// Splits pending requests into high and low classes and picks a winner.
`timescale 1ns/1ns
`default_nettype none

module priority_resolver
  import prio_pkg::*;
#(
  parameter int NSRC = 24
) (
  // Pending enabled requests and their priority bits.
  input  wire logic [NSRC-1:0] req,
  input  wire logic [NSRC-1:0] prio,
  // Global priority-levels enable.
  input  wire logic            levels_on,
  // Resolved classes and winning indices.
  output logic      [0:0]      unused_tie,
  output resolve_t             res
);

  logic [NSRC-1:0] high_vec;  // Requests in the high class.
  logic [NSRC-1:0] low_vec;   // Requests in the low class.

  // With levels off every request lands in one class, see [R2].
  genvar i;
  generate
    for (i = 0; i < NSRC; i++) begin : g_split
      assign high_vec[i] = req[i] & (prio[i] | ~levels_on);
      assign low_vec[i]  = req[i] & ~prio[i] & levels_on;
    end
  endgenerate

  // Lowest set bit wins; a fixed order keeps the pick predictable.
  function automatic logic [4:0] first_set(input logic [NSRC-1:0] v);
    logic [4:0] idx;
    idx = 5'h00;
    for (int k = NSRC - 1; k >= 0; k--) begin
      if (v[k]) begin
        idx = k[4:0];
      end
    end
    return idx;
  endfunction

  // Class summary handed back to the top.
  // One assignment keeps a single driver on the packed struct.
  assign res = {|high_vec, |low_vec, first_set(high_vec),
                first_set(low_vec)};
  assign unused_tie     = 1'b0;

endmodule

`default_nettype wire

/* tb/interrupt_priority_config_test.sv */
// Self-checking bench for the interrupt priority configuration block.
`timescale 1ns/1ns
`default_nettype none
`include "prio_defs.svh"

module interrupt_priority_config_test;
  import prio_pkg::*;

  // Ceiling on the run; the tests need under a hundred cycles.
  localparam int LIMIT = 5000;

  logic        clk;                     // System clock, 8 ns period.
  logic        rstn;                    // Active-low asynchronous reset.
  logic        psel;                    // APB select.
  logic        penable;                 // APB access phase.
  logic        pwrite;                  // APB direction.
  logic [11:0] paddr;                   // APB byte address.
  logic [31:0] pwdata;                  // APB write data.
  logic        pready;                  // APB answer.
  logic [31:0] prdata;                  // APB read data.
  logic        pslverr;                 // APB error.
  logic        wdt_ev;                  // Watchdog time-out event pulse.
  logic        pd_ev;                   // Power-down event pulse.
  logic [23:0] irq_request;             // Pending enabled requests.
  logic        irq_high;                // High-class request to the core.
  logic        irq_low;                 // Low-class request to the core.
  logic [4:0]  irq_index;               // Winning source.
  logic        levels_enabled;          // Copy of the levels enable.
  int          miscompares = 0;         // Mismatches seen.
  int          comparisons = 0;         // Comparisons made.
  int          cycles = 0;              // Clock cycles since time zero.
  logic [31:0] q;                       // Last read data.
  logic        e;                       // Last error flag.

  interrupt_priority_config #(.NSRC(24)) i_dut (
    .clk(clk), .rstn(rstn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
    .prdata(prdata), .pslverr(pslverr), .watchdog_timeout_event(wdt_ev),
    .power_down_event(pd_ev), .irq_request(irq_request),
    .irq_high(irq_high), .irq_low(irq_low), .irq_index(irq_index),
    .levels_enabled(levels_enabled)
  );

  // Free-running clock.
  always #4 clk = ~clk;

  // A hung handshake ends the run here, counted as a mismatch.
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == LIMIT) begin
      miscompares++;
      give_verdict();
    end
  end

  // Prints the counts and the verdict, then stops.
  task automatic give_verdict();
    $display("Checks %0d, mismatches %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // Compares a seen value against its expectation.
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      miscompares++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  // One APB transfer; the request holds until pready is sampled high.
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // Reads a register and compares data and error flag.
  task automatic rd(input logic [11:0] a, input logic [31:0] exp,
                    input logic err);
    apb(1'b0, a, 32'h0000_0000);
    check(q, exp);
    check({31'h0, e}, {31'h0, err});
  endtask

  // Drives one request pattern and checks the steering one cycle later.
  task automatic steer(input logic [23:0] r, input logic [6:0] exp);
    @(posedge clk);
    irq_request <= r;
    @(posedge clk);
    @(negedge clk);
    check({25'h0, irq_high, irq_low, irq_index}, {25'h0, exp});
  endtask

  // Pulses one of the flag-clearing events for a single cycle.
  task automatic pulse(input logic wdt);
    @(posedge clk);
    wdt_ev <= wdt;
    pd_ev <= ~wdt;
    @(posedge clk);
    wdt_ev <= 1'b0;
    pd_ev <= 1'b0;
  endtask

  initial begin
    clk = 1'b0;
    rstn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
    wdt_ev = 1'b0;
    pd_ev = 1'b0;
    irq_request = 24'h00_0000;
    repeat (5) @(posedge clk);
    rstn <= 1'b1;
    // Reset values of all registers.
    rd(`PRIO_ONE_OFFSET, 32'h0000_00FF, 1'b0);
    rd(`PRIO_TWO_OFFSET, 32'h0000_00FF, 1'b0);
    rd(`PRIO_THREE_OFFSET, 32'h0000_00FF, 1'b0);
    rd(`CTRL_OFFSET, 32'h0000_001C, 1'b0);
    check({31'h0, levels_enabled}, 32'h0000_0000);
    $display("Test reset values done");
    // Each priority register holds its own bits, back to back.
    apb(1'b1, `PRIO_ONE_OFFSET, 32'h0000_00A5);
    apb(1'b1, `PRIO_THREE_OFFSET, 32'h0000_003C);
    rd(`PRIO_ONE_OFFSET, 32'h0000_00A5, 1'b0);
    rd(`PRIO_THREE_OFFSET, 32'h0000_003C, 1'b0);
    rd(`PRIO_TWO_OFFSET, 32'h0000_00FF, 1'b0);
    rd(12'h010, 32'h0000_0000, 1'b1);
    $display("Test priority registers done");
    // Control register: unused bits ignore writes, events clear the read-only flags.
    apb(1'b1, `CTRL_OFFSET, 32'h0000_00FF);
    rd(`CTRL_OFFSET, 32'h0000_009F, 1'b0);
    check({31'h0, levels_enabled}, 32'h0000_0001);
    pulse(1'b1);
    rd(`CTRL_OFFSET, 32'h0000_0097, 1'b0);
    pulse(1'b0);
    rd(`CTRL_OFFSET, 32'h0000_0093, 1'b0);
    apb(1'b1, `CTRL_OFFSET, 32'h0000_0000);
    rd(`CTRL_OFFSET, 32'h0000_0000, 1'b0);
    $display("Test control register done");
    // With levels off a low-priority source still goes high.
    apb(1'b1, `PRIO_ONE_OFFSET, 32'h0000_0000);
    steer(24'h00_0008, 7'b10_00011);
    apb(1'b1, `CTRL_OFFSET, 32'h0000_0080);
    steer(24'h00_0008, 7'b01_00011);
    steer(24'h00_0208, 7'b10_01001);
    steer(24'h00_0000, 7'b00_00000);
    $display("Test steering done");
    give_verdict();
  end
endmodule
`default_nettype wire
